// [mdp_defines.svh]
`ifndef MDP_DEFINES_SVH
`define MDP_DEFINES_SVH

// register byte offsets
`define MDP_OFS_CTRL 8'h00
`define MDP_OFS_INSTR 8'h04
`define MDP_OFS_MBUS_IN 8'h08
`define MDP_OFS_SOR 8'h0C
`define MDP_OFS_GLB_IN 8'h10
`define MDP_OFS_STATUS 8'h14
`define MDP_OFS_ACC 8'h18
`define MDP_OFS_GLB_OUT 8'h1C
`define MDP_OFS_QUOT 8'h20
`define MDP_OFS_IDX 8'h24
`define MDP_OFS_MIR 8'h28
`define MDP_OFS_MOR 8'h2C
// instruction word field positions
`define MDP_F_OUT 0
`define MDP_F_IYLD 1
`define MDP_F_FSM 2
`define MDP_F_COEF 3
`define MDP_F_AIP 4
`define MDP_F_QST 5
`define MDP_F_LE 6
`define MDP_F_CADD 7
`define MDP_F_MBUS_LO 8
`define MDP_F_MBUS_HI 9
`define MDP_F_SUB 10
`define MDP_F_ACCLD 11
// control bits
`define MDP_C_XSYNC 0
`define MDP_C_SWRST 1
// widths and reset values
`define MDP_DW 16
`define MDP_GW 8
`define MDP_IXW 6
`define MDP_MOR_RST 16'hFFFF
`define MDP_PS_BITS 4'h8
`define MDP_SMAX 16'h7FFF
`define MDP_SMIN 16'h8000

`endif

// [mdp_pkg.sv]
package mdp_pkg;
  // transfer bus source select
  typedef enum logic [1:0] {
    MDP_MB_ACC = 2'h0,
    MDP_MB_MOR = 2'h1,
    MDP_MB_GLB = 2'h3
  } mdp_mbus_sel_t;
  // coefficient serialiser state, gray along idle-shift-last
  typedef enum logic [1:0] {
    MDP_PS_IDLE = 2'h0,
    MDP_PS_SHIFT = 2'h1,
    MDP_PS_LAST = 2'h3
  } mdp_ps_st_t;
endpackage

// [mdp_ps_conv.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mdp_defines.svh"
// parallel-to-serial coefficient converter, msb first
module mdp_ps_conv (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // load side
  input wire logic load,
  input wire logic step, // one instruction executed
  input wire logic [`MDP_GW-1:0] word,
  // serial side
  output logic bit_out,
  output logic busy
);
  import mdp_pkg::*;
  logic [`MDP_GW-1:0] sh_ff; // remaining bits
  logic [3:0] cnt_ff; // bits left to present
  mdp_ps_st_t st_ff;
  // one bit per instruction until the word is spent; bus waits never eat bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sh_ff <= '0;
      cnt_ff <= 4'h0;
      st_ff <= MDP_PS_IDLE;
    end else if (load) begin
      sh_ff <= word;
      cnt_ff <= `MDP_PS_BITS;
      st_ff <= MDP_PS_SHIFT;
    end else if (step) begin
      case (st_ff)
        MDP_PS_SHIFT: begin
          sh_ff <= {sh_ff[`MDP_GW-2:0], 1'b0};
          cnt_ff <= cnt_ff - 4'h1;
          if (cnt_ff == 4'h2) begin
            st_ff <= MDP_PS_LAST;
          end
        end
        MDP_PS_LAST: begin
          sh_ff <= '0;
          cnt_ff <= 4'h0;
          st_ff <= MDP_PS_IDLE;
        end
        default: st_ff <= MDP_PS_IDLE;
      endcase
    end
  end
  // the msb goes out the very cycle after load
  assign bit_out = (st_ff != MDP_PS_IDLE) & sh_ff[`MDP_GW-1];
  assign busy = (st_ff != MDP_PS_IDLE);
  a_ps_count: assert property (@(posedge clk) disable iff (!nrst)
    load |=> busy && cnt_ff == `MDP_PS_BITS) else $error("coef bit count wrong");
  a_ps_end: assert property (@(posedge clk) disable iff (!nrst)
    st_ff == MDP_PS_LAST && step && !load |=> !busy) else $error("coef not spent");
endmodule
`default_nettype wire

// [mdp_datapath.sv]
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mdp_defines.svh"
// Summary of operation
// - output op drives transfer bus to global
// - index load takes transfer bus value
// - array global indexed by sample/iteration index
// - new sample index usable two instructions later
// - state-machine op sets flag from sign
// - coefficient loads serialiser, sign bit first
// - coefficient is two's complement fraction; the adder weights its msb +1 like the other bits
// - one bit adds shift register, zero holds
// - serial coefficient only from a global
// - wide word truncated to global msbs
// - quotient store ends division, writes global
// - conditional step shifts positive-result bit
// - dividend sign routed into quotient automatically
// - sign-magnitude quotient stored as two's complement
// - one quotient bit per step, global width
// - unspecified fields use idle defaults
// - reset starts sample at first instruction
// - synced subroutines padded with idle steps
// - coupled slave data reaches master in time
// - write latch transparent, holds until enable
// - adder saturates on overflow
module mdp_datapath (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external sample reset pin
  input wire logic ext_sample_rst,
  // global store port
  output logic [`MDP_GW-1:0] glb_wdata,
  output logic [`MDP_IXW-1:0] glb_index,
  output logic glb_we,
  // sequencer position
  output logic [7:0] pc
);
  import mdp_pkg::*;
  // register copies
  logic [31:0] ctrl_ff; // sync mode and soft reset
  logic [`MDP_DW-1:0] mbus_in_ff; // memory value offered to mor
  logic [`MDP_DW-1:0] sor_ff; // shift output register
  logic [`MDP_GW-1:0] glb_in_ff; // incoming global word
  logic [`MDP_DW-1:0] acc_ff; // accumulator
  logic [`MDP_DW-1:0] mor_ff; // memory output register
  logic [`MDP_DW-1:0] mir_ff; // write latch
  logic [`MDP_IXW-1:0] sample_index_ff; // sample index
  logic [`MDP_IXW-1:0] sample_index_pend_ff; // sample index in flight
  logic sample_index_pend_v_ff; // pending load flag
  logic [`MDP_IXW-1:0] iteration_index_ff; // iteration index
  logic cflag_ff; // condition flag
  logic [`MDP_GW-1:0] quot_ff; // quotient collector
  logic [`MDP_GW-1:0] quot_st_ff; // stored quotient
  logic [1:0] sgn_hist_ff; // sor sign history
  logic qsign_ff; // dividend sign
  logic div_act_ff; // division in progress
  logic [`MDP_GW-1:0] glb_wdata_ff;
  logic glb_we_ff;
  logic [`MDP_IXW-1:0] glb_index_ff;
  logic [7:0] pc_ff;
  logic xr_s1_ff, xr_s2_ff, xr_s3_ff; // pin synchroniser and edge
  // one instruction strobe per accepted instruction write
  logic exec;
  logic [31:0] ins;
  logic coef_bit, ps_busy;
  logic [`MDP_DW-1:0] mbus, abus, bbus;
  logic [`MDP_DW:0] sum_w;
  logic [`MDP_DW-1:0] sum_sat;
  logic sample_start;
  // bus handshake state
  logic aw_ff, w_ff, bv_ff, rv_ff;
  logic [7:0] awa_ff, ara_ff;
  logic [31:0] wd_ff, rd_ff;
  logic wr_go;
  logic [31:0] rd_mux;
  logic rd_hit;

  // write side: latch address and data independently
  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awa_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wd_ff <= s_axi_wdata;
      end else if (wr_go) begin
        w_ff <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_ff && !bv_ff;
  assign s_axi_wready = !w_ff && !bv_ff;
  assign wr_go = aw_ff && w_ff && !bv_ff;
  // response follows both halves
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bv_ff <= 1'b0;
    end else if (wr_go) begin
      bv_ff <= 1'b1;
    end else if (s_axi_bready) begin
      bv_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = 2'h0;
  assign exec = wr_go && (awa_ff == `MDP_OFS_INSTR);
  assign ins = wd_ff;

  // control and operand registers from software
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_ff <= 32'h00000000;
      mbus_in_ff <= 16'h0000;
      glb_in_ff <= 8'h00;
    end else if (wr_go) begin
      case (awa_ff)
        `MDP_OFS_CTRL: ctrl_ff <= {30'h0, wd_ff[1:0]};
        `MDP_OFS_MBUS_IN: mbus_in_ff <= wd_ff[`MDP_DW-1:0];
        `MDP_OFS_GLB_IN: glb_in_ff <= wd_ff[`MDP_GW-1:0];
        default: ctrl_ff <= {ctrl_ff[31:2], 1'b0, ctrl_ff[0]}; // soft reset self-clears
      endcase
    end else begin
      ctrl_ff[`MDP_C_SWRST] <= 1'b0;
    end
  end

  // external reset pin passes two flops before use
  always_ff @(posedge clk) begin
    if (!nrst) begin
      xr_s1_ff <= 1'b0;
      xr_s2_ff <= 1'b0;
      xr_s3_ff <= 1'b0;
    end else begin
      xr_s1_ff <= ext_sample_rst;
      xr_s2_ff <= xr_s1_ff;
      xr_s3_ff <= xr_s2_ff;
    end
  end
  // with external sync only the pin starts samples
  assign sample_start = ctrl_ff[`MDP_C_XSYNC] ? (xr_s2_ff && !xr_s3_ff)
                                              : ctrl_ff[`MDP_C_SWRST];

  // sequencer position and iteration index
  always_ff @(posedge clk) begin
    if (!nrst || sample_start) begin
      pc_ff <= 8'h00;
      iteration_index_ff <= '0;
    end else if (exec) begin
      pc_ff <= pc_ff + 8'h01;
      if (ins[`MDP_F_SUB] && pc_ff == 8'h00) begin
        iteration_index_ff <= iteration_index_ff + 6'h01;
      end
    end
  end
  assign pc = pc_ff;

  // transfer bus mux; accumulator when unspecified
  always_comb begin
    case (mdp_mbus_sel_t'(ins[`MDP_F_MBUS_HI:`MDP_F_MBUS_LO]))
      MDP_MB_MOR: mbus = mor_ff;
      MDP_MB_GLB: mbus = {glb_in_ff, 8'h00};
      default: mbus = acc_ff;
    endcase
  end

  mdp_ps_conv u_ps (
    .clk(clk),
    .nrst(nrst),
    .load(exec && ins[`MDP_F_COEF]),
    .step(exec),
    .word(glb_in_ff),
    .bit_out(coef_bit),
    .busy(ps_busy)
  );

  // adder: coef-gated sor plus accumulator, fractional msb-first weights
  assign abus = (ins[`MDP_F_CADD] && !coef_bit) ? 16'h0000 : sor_ff;
  assign bbus = ins[`MDP_F_ACCLD] ? 16'h0000 : acc_ff;
  assign sum_w = {abus[`MDP_DW-1], abus} + {bbus[`MDP_DW-1], bbus};
  // clip instead of wrapping, sign from the extra bit
  always_comb begin
    if (sum_w[`MDP_DW] != sum_w[`MDP_DW-1]) begin
      sum_sat = sum_w[`MDP_DW] ? `MDP_SMIN : `MDP_SMAX;
    end else begin
      sum_sat = sum_w[`MDP_DW-1:0];
    end
  end

  // pipeline registers: mor refreshes to default when idle, acc and mir hold
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_ff <= 16'h0000;
      mor_ff <= `MDP_MOR_RST;
      mir_ff <= 16'h0000;
    end else if (exec) begin
      mor_ff <= ins[`MDP_F_MBUS_LO] ? mbus_in_ff : `MDP_MOR_RST;
      if (ins[`MDP_F_LE]) begin
        mir_ff <= mbus;
      end
      if (ins[`MDP_F_AIP]) begin
        if (!sum_sat[`MDP_DW-1]) begin
          acc_ff <= sum_sat;
        end
      end else if (ins[`MDP_F_CADD] || ins[`MDP_F_ACCLD]) begin
        acc_ff <= sum_sat;
      end
    end
  end

  // sor steps right one bit per add, else holds
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sor_ff <= 16'h0000;
    end else if (wr_go && awa_ff == `MDP_OFS_SOR) begin
      sor_ff <= wd_ff[`MDP_DW-1:0];
    end else if (exec && (ins[`MDP_F_CADD] || ins[`MDP_F_AIP])) begin
      sor_ff <= {sor_ff[`MDP_DW-1], sor_ff[`MDP_DW-1:1]};
    end
  end

  // sample index loads through a one-instruction delay stage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sample_index_ff <= '0;
      sample_index_pend_ff <= '0;
      sample_index_pend_v_ff <= 1'b0;
    end else if (exec) begin
      if (sample_index_pend_v_ff) begin
        sample_index_ff <= sample_index_pend_ff;
      end
      sample_index_pend_v_ff <= ins[`MDP_F_IYLD];
      if (ins[`MDP_F_IYLD]) begin
        sample_index_pend_ff <= mbus[`MDP_IXW-1:0];
      end
    end
  end

  // decision flag from accumulator sign, before aip gating
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cflag_ff <= 1'b0;
    end else if (exec && ins[`MDP_F_FSM]) begin
      cflag_ff <= acc_ff[`MDP_DW-1];
    end
  end

  // divider: sign history, collector and store
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sgn_hist_ff <= 2'h0;
      qsign_ff <= 1'b0;
      div_act_ff <= 1'b0;
      quot_ff <= '0;
      quot_st_ff <= '0;
    end else if (exec) begin
      sgn_hist_ff <= {sgn_hist_ff[0], sor_ff[`MDP_DW-1]};
      if (ins[`MDP_F_AIP]) begin
        if (!div_act_ff) begin
          qsign_ff <= sgn_hist_ff[1];
          // first step already yields the top magnitude bit
          quot_ff <= {{(`MDP_GW-1){1'b0}}, !sum_sat[`MDP_DW-1]};
          div_act_ff <= 1'b1;
        end else begin
          quot_ff <= {quot_ff[`MDP_GW-2:0], !sum_sat[`MDP_DW-1]};
        end
      end
      if (ins[`MDP_F_QST]) begin
        div_act_ff <= 1'b0;
        quot_st_ff <= qsign_ff ? (~quot_ff + 8'h01) : quot_ff;
      end
    end
  end

  // global output port, msb-justified truncation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      glb_wdata_ff <= '0;
      glb_we_ff <= 1'b0;
      glb_index_ff <= '0;
    end else begin
      glb_we_ff <= exec && (ins[`MDP_F_OUT] || ins[`MDP_F_QST]);
      if (exec && ins[`MDP_F_QST]) begin
        glb_wdata_ff <= qsign_ff ? (~quot_ff + 8'h01) : quot_ff;
      end else if (exec && ins[`MDP_F_OUT]) begin
        glb_wdata_ff <= mbus[`MDP_DW-1:`MDP_DW-`MDP_GW];
      end
      if (exec) begin
        glb_index_ff <= ins[`MDP_F_SUB] ? iteration_index_ff : sample_index_ff;
      end
    end
  end
  assign glb_wdata = glb_wdata_ff;
  assign glb_we = glb_we_ff;
  assign glb_index = glb_index_ff;
  // idle padding of synced subroutines and coupled return timing are
  // scheduled by the sequencer; this block keeps nop as pure refresh
  // so padded steps leave acc, sor and mir alone but still step the serialiser and sign history

  // read side
  always_comb begin
    rd_hit = 1'b1;
    case (ara_ff)
      `MDP_OFS_CTRL: rd_mux = ctrl_ff;
      `MDP_OFS_STATUS: rd_mux = {28'h0, div_act_ff, ps_busy, coef_bit, cflag_ff};
      `MDP_OFS_SOR: rd_mux = {16'h0, sor_ff};
      `MDP_OFS_ACC: rd_mux = {16'h0, acc_ff};
      `MDP_OFS_GLB_OUT: rd_mux = {24'h0, glb_wdata_ff};
      `MDP_OFS_QUOT: rd_mux = {24'h0, quot_st_ff};
      `MDP_OFS_IDX: rd_mux = {8'h0, pc_ff, 2'h0, iteration_index_ff, 2'h0, sample_index_ff};
      `MDP_OFS_MIR: rd_mux = {16'h0, mir_ff};
      `MDP_OFS_MOR: rd_mux = {16'h0, mor_ff};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end
  // one-cycle read path; unmapped answers decode error
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rv_ff <= 1'b0;
      ara_ff <= 8'h00;
      rd_ff <= 32'h00000000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ara_ff <= s_axi_araddr;
      rv_ff <= 1'b1;
    end else if (rv_ff && s_axi_rready) begin
      rv_ff <= 1'b0;
    end
  end
  assign s_axi_arready = !rv_ff;
  assign s_axi_rdata = rv_ff ? rd_mux : 32'h00000000;
  assign s_axi_rresp = (rv_ff && !rd_hit) ? 2'h3 : 2'h0;
  assign s_axi_rvalid = rv_ff;

  a_sidx_delay: assert property (@(posedge clk) disable iff (!nrst)
    exec && ins[`MDP_F_IYLD] && !sample_index_pend_v_ff |=>
    sample_index_ff == $past(sample_index_ff)) else $error("index too early");
  a_sat_hold: assert property (@(posedge clk) disable iff (!nrst)
    exec && ins[`MDP_F_CADD] && !ins[`MDP_F_AIP] |=> acc_ff == $past(sum_sat))
    else $error("acc not sum");
  a_mor_dflt: assert property (@(posedge clk) disable iff (!nrst)
    exec && !ins[`MDP_F_MBUS_LO] |=> mor_ff == `MDP_MOR_RST) else $error("mor default");
  a_out_trunc: assert property (@(posedge clk) disable iff (!nrst)
    exec && ins[`MDP_F_OUT] && !ins[`MDP_F_QST] |=> glb_we &&
    glb_wdata == $past(mbus[15:8])) else $error("global out wrong");
  a_flag_sign: assert property (@(posedge clk) disable iff (!nrst)
    exec && ins[`MDP_F_FSM] |=> cflag_ff == $past(acc_ff[15])) else $error("flag");
  a_mir_hold: assert property (@(posedge clk) disable iff (!nrst)
    exec && !ins[`MDP_F_LE] |=> $stable(mir_ff)) else $error("mir moved");
  a_pc_reset: assert property (@(posedge clk) disable iff (!nrst)
    sample_start |=> pc_ff == 8'h00) else $error("pc not reset");
  a_idx_sel: assert property (@(posedge clk) disable iff (!nrst)
    exec && ins[`MDP_F_SUB] |=> glb_index == $past(iteration_index_ff))
    else $error("index sel");
endmodule
`default_nettype wire

// [mdp_glb_model.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mdp_defines.svh"
// far-side global store: records every word the block pushes out
module mdp_glb_model (
  // clock
  input wire logic clk,
  // global store port from the block
  input wire logic [`MDP_GW-1:0] glb_wdata,
  input wire logic [`MDP_IXW-1:0] glb_index,
  input wire logic glb_we,
  // external sample clock toward the block
  output logic ext_sample_rst
);
  logic [`MDP_GW-1:0] last_data_ff; // most recent pushed word
  logic [`MDP_IXW-1:0] last_idx_ff; // element that word went to
  int wr_cnt_ff; // pushes seen so far

  // quiet pin and empty store at time zero
  initial begin
    ext_sample_rst = 1'b0;
    last_data_ff = '0;
    last_idx_ff = '0;
    wr_cnt_ff = 0;
  end

  // capture only on the strobe, so a stuck strobe shows up as extra counts
  always @(posedge clk) begin
    if (glb_we) begin
      last_data_ff <= glb_wdata;
      last_idx_ff <= glb_index;
      wr_cnt_ff <= wr_cnt_ff + 1;
    end
  end

  // one external clock edge; held several cycles so the synchroniser sees it
  task automatic pulse_sample();
    @(posedge clk);
    ext_sample_rst <= 1'b1;
    repeat (4) @(posedge clk);
    ext_sample_rst <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [mdp_datapath_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mdp_defines.svh"
// self-checking bench: instructions issued one by one over the register bus
module mdp_datapath_tb_top;
  logic clk;
  logic nrst;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic ext_sample_rst;
  logic [`MDP_GW-1:0] glb_wdata;
  logic [`MDP_IXW-1:0] glb_index;
  logic glb_we;
  logic [7:0] pc;
  logic [31:0] rd_data; // last read word
  logic [1:0] last_resp; // last response code
  int err_count;
  int num_checks;

  mdp_datapath u_mdp_datapath (.clk(clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_sample_rst(ext_sample_rst),
    .glb_wdata(glb_wdata), .glb_index(glb_index), .glb_we(glb_we), .pc(pc));

  mdp_glb_model u_mdp_glb_model (.clk(clk), .glb_wdata(glb_wdata), .glb_index(glb_index),
    .glb_we(glb_we), .ext_sample_rst(ext_sample_rst));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // one comparison, counted; four-state equality so an unknown matches only the same unknown
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bus write: both halves offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    if (n >= 100) err_count++;
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  // bus read: ready held until the data beat is sampled
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    if (n >= 100) err_count++;
    rd_data = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // bounded wait for the sequencer to return to its first instruction
  task automatic wait_pc0();
    int n;
    n = 0;
    while (pc !== 8'h00 && n < 20) begin
      @(posedge clk);
      n++;
    end
  endtask

  // single exit point for normal end and watchdog alike
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog sized far above the few hundred cycles the sequence needs
  initial begin
    #200000;
    err_count++;
    final_report();
  end

  // main sequence
  initial begin
    err_count = 0;
    num_checks = 0;
    nrst = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("pc after reset", pc, 32'h0);
    rd(`MDP_OFS_MOR);
    chk("idle mor", rd_data[15:0], `MDP_MOR_RST);
    rd(8'h30);
    chk("unmapped read resp", last_resp, 32'h3);
    wr(8'h30, 32'h5A);
    chk("unmapped write resp", last_resp, 32'h0);
    // acc loaded from the shift register, then pushed out on the default bus
    wr(`MDP_OFS_SOR, 32'h1234);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_ACCLD);
    rd(`MDP_OFS_ACC);
    chk("acc", rd_data[15:0], 32'h1234);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_OUT);
    chk("global word", u_mdp_glb_model.last_data_ff, 32'h12);
    // transparent latch keeps its value across an idle step
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_LE);
    wr(`MDP_OFS_INSTR, 32'h0);
    rd(`MDP_OFS_MIR);
    chk("latch after idle", rd_data[15:0], 32'h1234);
    // flag follows accumulator sign, both polarities
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_FSM);
    rd(`MDP_OFS_STATUS);
    chk("flag positive", rd_data[0], 32'h0);
    wr(`MDP_OFS_SOR, 32'h8000);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_ACCLD);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_FSM);
    rd(`MDP_OFS_STATUS);
    chk("flag negative", rd_data[0], 32'h1);
    // transfer bus sourced from the external global
    wr(`MDP_OFS_GLB_IN, 32'hA5);
    wr(`MDP_OFS_INSTR, (32'h1 << `MDP_F_OUT) | (32'h3 << `MDP_F_MBUS_LO));
    chk("global from input", u_mdp_glb_model.last_data_ff, 32'hA5);
    // new index invisible to the next instruction, visible to the one after
    wr(`MDP_OFS_SOR, 32'h0005);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_ACCLD);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_IYLD);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_OUT);
    chk("index next instr", u_mdp_glb_model.last_idx_ff, 32'h0);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_OUT);
    chk("index second instr", u_mdp_glb_model.last_idx_ff, 32'h5);
    rd(`MDP_OFS_IDX);
    chk("sample index", rd_data[5:0], 32'h5);
    chk("push count", u_mdp_glb_model.wr_cnt_ff, 32'h4);
    rd(`MDP_OFS_MOR);
    chk("mor after idle steps", rd_data[15:0], `MDP_MOR_RST);
    // subprogram selects the iteration index, still zero
    wr(`MDP_OFS_INSTR, (32'h1 << `MDP_F_OUT) | (32'h1 << `MDP_F_SUB));
    chk("index in subprogram", u_mdp_glb_model.last_idx_ff, 32'h0);
    // 0.5 times 0.5 by eight coefficient steps
    wr(`MDP_OFS_SOR, 32'h0);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_ACCLD);
    wr(`MDP_OFS_SOR, 32'h4000);
    wr(`MDP_OFS_GLB_IN, 32'h40);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_COEF);
    repeat (8) wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_CADD);
    rd(`MDP_OFS_ACC);
    chk("product", rd_data[15:0], 32'h2000);
    rd(`MDP_OFS_STATUS);
    chk("coef spent", rd_data[2], 32'h0);
    // 0.25 over 0.5 by seven conditional steps
    wr(`MDP_OFS_SOR, 32'h2000);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_ACCLD);
    wr(`MDP_OFS_SOR, 32'hE000);
    wr(`MDP_OFS_INSTR, 32'h0);
    repeat (7) wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_AIP);
    wr(`MDP_OFS_INSTR, 32'h1 << `MDP_F_QST);
    chk("quotient pushed", u_mdp_glb_model.last_data_ff, 32'h40);
    rd(`MDP_OFS_QUOT);
    chk("quotient stored", rd_data[7:0], 32'h40);
    // software sample restart
    wr(`MDP_OFS_CTRL, 32'h2);
    wait_pc0();
    chk("pc soft restart", pc, 32'h0);
    // external sample restart through the synchroniser
    wr(`MDP_OFS_CTRL, 32'h1);
    wr(`MDP_OFS_INSTR, 32'h0);
    wr(`MDP_OFS_INSTR, 32'h0);
    u_mdp_glb_model.pulse_sample();
    wait_pc0();
    chk("pc external restart", pc, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
